// ===== logic/mac_stat_counters.sv
`timescale 1ns/1ps
module mac_stat_counters
  import stat_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // software register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata_q,
  // transmit side events
  input  wire logic              tx_done,
  input  wire tx_status_t        tx_status,
  input  wire logic              tx_underrun,
  // receive side events
  input  wire logic              rx_active,
  input  wire logic              rx_er,
  input  wire logic              rx_done,
  input  wire rx_status_t        rx_status,
  input  wire logic              ru_no_resources,
  // dump image writer
  output logic                   dump_wr_valid,
  output dump_word_t             dump_wr,
  input  wire logic              dump_wr_ready
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } dump_state_t;

  dump_state_t        state_q;
  logic [IDX_W-1:0]   idx_q;
  logic               reset_mode_q;
  logic               done_q;
  logic               save_bad_q;
  logic               rx_er_seen_q;
  logic [NUM_CNT-1:0] inc;
  logic [COLL_W-1:0]  coll_add;
  logic [CNT_W-1:0]   bank_rdata;
  logic               rx_short;
  logic               rx_align;
  logic               rx_crc;
  logic               cmd_wr;
  logic [2:0]         cmd_code;
  logic               start_dump;
  logic               word_taken;
  logic               last_word;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------

  // command opcode sits in the low bits of a command write
  assign cmd_wr     = reg_wr && reg_addr == REG_CMD;
  assign cmd_code   = reg_wdata[CMD_LSB +: 3];
  // commands arriving during a dump are dropped, not queued
  assign start_dump = cmd_wr && state_q == ST_IDLE &&
                      (cmd_code == CMD_DUMP ||
                       cmd_code == CMD_DUMP_RESET);

  // configuration: save-bad-frames steers the resource count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      save_bad_q <= CFG_SAVE_RST;
    end else if (reg_wr && reg_addr == REG_CFG) begin
      save_bad_q <= reg_wdata[CFG_SAVE_BIT];
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata_q <= 32'h0000_0000;
      case (reg_addr)
        REG_STATUS: begin
          reg_rdata_q[ST_BUSY_BIT] <= state_q != ST_IDLE;
          reg_rdata_q[ST_DONE_BIT] <= done_q;
          reg_rdata_q[ST_MODE_BIT] <= reset_mode_q;
        end
        REG_CFG: begin
          reg_rdata_q[CFG_SAVE_BIT] <= save_bad_q;
        end
        default: begin
          reg_rdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // transmit and receive event decode
  // ---------------------------------------------------------------

  // every tx counter except underrun is qualified by the end-of-frame
  // strobe; a frame may light several of them at once
  always_comb begin
    inc                = '0;
    inc[I_TX_GOOD]     = tx_done && tx_status.good;
    inc[I_TX_MAXCOLL]  = tx_done && tx_status.max_coll;
    inc[I_TX_LATE]     = tx_done && tx_status.late_coll;
    inc[I_TX_UNDER]    = tx_underrun;
    inc[I_TX_LOSTCRS]  = tx_done && tx_status.good &&
                         tx_status.lost_crs;
    inc[I_TX_DEFER]    = tx_done && tx_status.deferred;
    inc[I_TX_SINGLE]   = tx_done && tx_status.good &&
                         tx_status.coll == COLL_W'(1);
    inc[I_TX_MULTI]    = tx_done && tx_status.good &&
                         tx_status.coll > COLL_W'(1);
    inc[I_RX_GOOD]     = rx_done && rx_status.good_stored;
    inc[I_RX_CRC]      = rx_done && rx_crc;
    inc[I_RX_ALIGN]    = rx_done && rx_align;
    inc[I_RX_RES]      = rx_done &&
                         (ru_no_resources ||
                          (rx_status.no_buffer &&
                           !(save_bad_q && rx_status.bad)));
  end

  // total collisions adds the whole per-frame count in one go
  assign coll_add = tx_done ? tx_status.coll : '0;

  // ---------------------------------------------------------------
  // receive error classification
  // ---------------------------------------------------------------

  // the media error pin is remembered across the frame so it can
  // only ever add one crc count, at the frame's end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_er_seen_q <= 1'b0;
    end else if (rx_done) begin
      rx_er_seen_q <= 1'b0;
    end else if (rx_active && rx_er) begin
      rx_er_seen_q <= 1'b1;
    end
  end

  // short wins over alignment, alignment over plain crc; the short
  // counter itself lives outside this bank
  assign rx_short = rx_status.short_frame;
  assign rx_align = !rx_short && rx_status.misaligned &&
                    rx_status.crc_err;
  assign rx_crc   = !rx_short && !rx_align &&
                    (rx_status.crc_err || rx_er_seen_q ||
                     (rx_active && rx_er));

  // ---------------------------------------------------------------
  // dump engine
  // ---------------------------------------------------------------

  assign word_taken = state_q == ST_WRITE && dump_wr_ready;
  assign last_word  = idx_q == LAST_IDX;

  // walks the bank one word per read/write pair; write side may
  // stall the walk for as long as it likes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_dump) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          state_q <= ST_WRITE;
        end
        ST_WRITE: begin
          if (word_taken) begin
            state_q <= last_word ? ST_IDLE : ST_READ;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // word index and dump flavour
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idx_q        <= '0;
      reset_mode_q <= 1'b0;
    end else if (start_dump) begin
      idx_q        <= '0;
      reset_mode_q <= cmd_code == CMD_DUMP_RESET;
    end else if (word_taken && !last_word) begin
      idx_q        <= idx_q + IDX_W'(1);
    end
  end

  // completion flag: set on the last word, cleared by a status read
  // or a new dump; the set wins a same-cycle clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else if (word_taken && last_word) begin
      done_q <= 1'b1;
    end else if ((reg_rd && reg_addr == REG_STATUS) || start_dump) begin
      done_q <= 1'b0;
    end
  end

  assign dump_wr_valid = state_q == ST_WRITE;
  assign dump_wr.addr  = {2'b00, idx_q, 2'b00};
  assign dump_wr.data  = bank_rdata;

  // capture and clear happen on the same edge per counter, so an
  // event arriving then lands in the fresh count
  stat_counter_bank u_bank (
    .core_clk (core_clk),
    .nrst     (nrst),
    .inc      (inc),
    .coll_add (coll_add),
    .rd_en    (state_q == ST_READ),
    .clr_en   (state_q == ST_READ && reset_mode_q),
    .rd_idx   (idx_q),
    .rdata_q  (bank_rdata)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  property p_inc_at_end;
    @(posedge core_clk) disable iff (!nrst)
    (|inc) |-> (tx_done || rx_done || tx_underrun);
  endproperty
  a_inc_at_end: assert property (p_inc_at_end)
    else $error("counter bumped outside frame end");

  property p_dump_start;
    @(posedge core_clk) disable iff (!nrst)
    start_dump |=> state_q == ST_READ ##1 dump_wr_valid;
  endproperty
  a_dump_start: assert property (p_dump_start)
    else $error("dump did not start");

  property p_tx_good;
    @(posedge core_clk) disable iff (!nrst)
    inc[I_TX_GOOD] |-> tx_done && tx_status.good && !inc[I_TX_LATE];
  endproperty
  a_tx_good: assert property (p_tx_good)
    else $error("tx good counted without good completion");

  property p_single_coll;
    @(posedge core_clk) disable iff (!nrst)
    inc[I_TX_SINGLE] |-> coll_add == COLL_W'(1) && !inc[I_TX_MULTI];
  endproperty
  a_single_coll: assert property (p_single_coll)
    else $error("single collision count wrong");

  property p_total_coll;
    @(posedge core_clk) disable iff (!nrst)
    inc[I_TX_MULTI] |-> coll_add > COLL_W'(1);
  endproperty
  a_total_coll: assert property (p_total_coll)
    else $error("total collisions not added");

  property p_rx_er_once;
    @(posedge core_clk) disable iff (!nrst)
    rx_done |=> !rx_er_seen_q || (rx_active && $past(rx_er));
  endproperty
  a_rx_er_once: assert property (p_rx_er_once)
    else $error("rx error memory not cleared at frame end");

  property p_rx_excl;
    @(posedge core_clk) disable iff (!nrst)
    rx_done |-> $onehot0({inc[I_RX_CRC], inc[I_RX_ALIGN], rx_short}) ||
                !(inc[I_RX_CRC] || inc[I_RX_ALIGN]);
  endproperty
  a_rx_excl: assert property (p_rx_excl)
    else $error("rx error counters not exclusive");

  property p_res_bad;
    @(posedge core_clk) disable iff (!nrst)
    inc[I_RX_RES] && save_bad_q && rx_status.bad |-> ru_no_resources;
  endproperty
  a_res_bad: assert property (p_res_bad)
    else $error("saved bad frame counted as resource error");

  property p_dump_walk;
    @(posedge core_clk) disable iff (!nrst)
    word_taken && !last_word |=> state_q == ST_READ &&
                                 idx_q == $past(idx_q) + IDX_W'(1);
  endproperty
  a_dump_walk: assert property (p_dump_walk)
    else $error("dump walk skipped a counter");

  property p_underrun;
    @(posedge core_clk) disable iff (!nrst)
    tx_underrun |-> inc[I_TX_UNDER];
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun event not counted");

  property p_res_nores;
    @(posedge core_clk) disable iff (!nrst)
    rx_done && ru_no_resources |-> inc[I_RX_RES];
  endproperty
  a_res_nores: assert property (p_res_nores)
    else $error("frame in no-resources state not counted");

  property p_er_in_frame;
    @(posedge core_clk) disable iff (!nrst)
    $rose(rx_er_seen_q) |-> $past(rx_active) && $past(rx_er);
  endproperty
  a_er_in_frame: assert property (p_er_in_frame)
    else $error("rx error memory set outside a frame");

  property p_dump_hold;
    @(posedge core_clk) disable iff (!nrst)
    dump_wr_valid && !dump_wr_ready |=> dump_wr_valid && $stable(dump_wr);
  endproperty
  a_dump_hold: assert property (p_dump_hold)
    else $error("dump word changed while stalled");

  property p_busy_cmd;
    @(posedge core_clk) disable iff (!nrst)
    cmd_wr && state_q != ST_IDLE |=> $stable(reset_mode_q);
  endproperty
  a_busy_cmd: assert property (p_busy_cmd)
    else $error("command taken while dump busy");

  property p_dump_end;
    @(posedge core_clk) disable iff (!nrst)
    word_taken && last_word |=> state_q == ST_IDLE && done_q;
  endproperty
  a_dump_end: assert property (p_dump_end)
    else $error("dump did not finish after last word");

endmodule

// ===== logic/stat_pkg.sv
package stat_pkg;

  // ---------------------------------------------------------------
  // counter bank geometry
  // ---------------------------------------------------------------
  localparam int          CNT_W    = 32;
  localparam int          NUM_CNT  = 13;
  localparam int          IDX_W    = 4;
  localparam int          COLL_W   = 5;
  localparam logic [31:0] CNT_RST  = 32'h0000_0000;

  // byte offsets of each counter in the dump image
  localparam logic [7:0] OFF_TX_GOOD    = 8'h00;
  localparam logic [7:0] OFF_TX_MAXCOLL = 8'h04;
  localparam logic [7:0] OFF_TX_LATE    = 8'h08;
  localparam logic [7:0] OFF_TX_UNDER   = 8'h0c;
  localparam logic [7:0] OFF_TX_LOSTCRS = 8'h10;
  localparam logic [7:0] OFF_TX_DEFER   = 8'h14;
  localparam logic [7:0] OFF_TX_SINGLE  = 8'h18;
  localparam logic [7:0] OFF_TX_MULTI   = 8'h1c;
  localparam logic [7:0] OFF_TX_TOTAL   = 8'h20;
  localparam logic [7:0] OFF_RX_GOOD    = 8'h24;
  localparam logic [7:0] OFF_RX_CRC     = 8'h28;
  localparam logic [7:0] OFF_RX_ALIGN   = 8'h2c;
  localparam logic [7:0] OFF_RX_RES     = 8'h30;

  // counter index is the byte offset divided by four
  localparam int I_TX_GOOD    = OFF_TX_GOOD    / 4;
  localparam int I_TX_MAXCOLL = OFF_TX_MAXCOLL / 4;
  localparam int I_TX_LATE    = OFF_TX_LATE    / 4;
  localparam int I_TX_UNDER   = OFF_TX_UNDER   / 4;
  localparam int I_TX_LOSTCRS = OFF_TX_LOSTCRS / 4;
  localparam int I_TX_DEFER   = OFF_TX_DEFER   / 4;
  localparam int I_TX_SINGLE  = OFF_TX_SINGLE  / 4;
  localparam int I_TX_MULTI   = OFF_TX_MULTI   / 4;
  localparam int I_TX_TOTAL   = OFF_TX_TOTAL   / 4;
  localparam int I_RX_GOOD    = OFF_RX_GOOD    / 4;
  localparam int I_RX_CRC     = OFF_RX_CRC     / 4;
  localparam int I_RX_ALIGN   = OFF_RX_ALIGN   / 4;
  localparam int I_RX_RES     = OFF_RX_RES     / 4;
  localparam logic [IDX_W-1:0] LAST_IDX = 4'hc;

  // ---------------------------------------------------------------
  // software register port
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG    = 8'h08;

  // command field position and codes
  localparam int         CMD_LSB        = 0;
  localparam logic [2:0] CMD_NOP        = 3'h0;
  localparam logic [2:0] CMD_DUMP       = 3'h1;
  localparam logic [2:0] CMD_DUMP_RESET = 3'h2;

  // status and config bit positions, reset values
  localparam int   ST_BUSY_BIT   = 0;
  localparam int   ST_DONE_BIT   = 1;
  localparam int   ST_MODE_BIT   = 2;
  localparam int   CFG_SAVE_BIT  = 0;
  localparam logic CFG_SAVE_RST  = 1'b0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              good;
    logic              max_coll;
    logic              late_coll;
    logic              lost_crs;
    logic              deferred;
    logic [COLL_W-1:0] coll;
  } tx_status_t;

  typedef struct packed {
    logic good_stored;
    logic crc_err;
    logic misaligned;
    logic short_frame;
    logic no_buffer;
    logic bad;
  } rx_status_t;

  typedef struct packed {
    logic [7:0]       addr;
    logic [CNT_W-1:0] data;
  } dump_word_t;

endpackage

// ===== logic/stat_counter_bank.sv
`timescale 1ns/1ps
module stat_counter_bank
  import stat_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic [NUM_CNT-1:0]   inc,
  input  wire logic [COLL_W-1:0]    coll_add,
  input  wire logic                 rd_en,
  input  wire logic                 clr_en,
  input  wire logic [IDX_W-1:0]     rd_idx,
  output logic      [CNT_W-1:0]     rdata_q
);

  logic [CNT_W-1:0] cnt_q [NUM_CNT];

  // ---------------------------------------------------------------
  // amount added to one counter this cycle
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] step(input int i,
                                            input logic b,
                                            input logic [COLL_W-1:0] n);
    if (i == I_TX_TOTAL) begin
      step = {{(CNT_W-COLL_W){1'b0}}, n};
    end else begin
      step = {{(CNT_W-1){1'b0}}, b};
    end
  endfunction

  // counters wrap silently; a clear keeps this cycle's event so
  // nothing is lost between snapshot and zeroing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_q[i] <= CNT_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CNT; i++) begin
        if (clr_en && rd_idx == IDX_W'(i)) begin
          cnt_q[i] <= step(i, inc[i], coll_add);
        end else begin
          cnt_q[i] <= cnt_q[i] + step(i, inc[i], coll_add);
        end
      end
    end
  end

  // registered read port holds the pre-update value
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= CNT_RST;
    end else if (rd_en) begin
      rdata_q <= cnt_q[rd_idx];
    end
  end

endmodule

// ===== test/dump_sink.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host side that takes the counter dump image word by word
// ---------------------------------------------------------------
module dump_sink
  import stat_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       slow,
  input  wire logic       clr,
  input  wire logic       dump_wr_valid,
  input  wire dump_word_t dump_wr,
  output logic            dump_wr_ready
);
  logic [1:0]       tick_q;
  logic [CNT_W-1:0] mem [0:15];
  logic [7:0]       ord [0:15];
  int               n_acc = 0;

  // free-running phase; a slow host takes a word one cycle in four
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= 2'h0;
    end else begin
      tick_q <= tick_q + 2'h1;
    end
  end
  assign dump_wr_ready = !slow || (tick_q == 2'h3);

  // keep each accepted word by offset, and the arrival order
  always @(posedge core_clk) begin
    if (clr) begin
      n_acc <= 0;
    end else if (dump_wr_valid && dump_wr_ready && n_acc < 16) begin
      mem[dump_wr.addr[5:2]] <= dump_wr.data;
      ord[n_acc]             <= dump_wr.addr;
      n_acc                  <= n_acc + 1;
    end
  end
endmodule

// ===== test/tb_mac_stat_counters.sv
`timescale 1ns/1ps
module tb_mac_stat_counters
  import stat_pkg::*;
();
  logic             core_clk = 1'b0;
  logic             nrst = 1'b0;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [31:0]      reg_rdata_q;
  logic             tx_done = 1'b0;
  tx_status_t       tx_status = '0;
  logic             tx_underrun = 1'b0;
  logic             rx_active = 1'b0;
  logic             rx_er = 1'b0;
  logic             rx_done = 1'b0;
  rx_status_t       rx_status = '0;
  logic             ru_no_resources = 1'b0;
  logic             dump_wr_valid;
  dump_word_t       dump_wr;
  logic             dump_wr_ready;
  logic             slow = 1'b0;
  logic             clr = 1'b0;
  logic             save_bad = 1'b0;
  logic [CNT_W-1:0] expect_cnt [0:NUM_CNT-1];
  int               fails = 0;
  int               comparisons = 0;
  int               cycles = 0;

  mac_stat_counters DUT (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .tx_done(tx_done), .tx_status(tx_status),
    .tx_underrun(tx_underrun), .rx_active(rx_active), .rx_er(rx_er),
    .rx_done(rx_done), .rx_status(rx_status),
    .ru_no_resources(ru_no_resources), .dump_wr_valid(dump_wr_valid),
    .dump_wr(dump_wr), .dump_wr_ready(dump_wr_ready));

  dump_sink sink (
    .core_clk(core_clk), .nrst(nrst), .slow(slow), .clr(clr),
    .dump_wr_valid(dump_wr_valid), .dump_wr(dump_wr),
    .dump_wr_ready(dump_wr_ready));

  // ---------------------------------------------------------------
  // clock, hang guard and common tasks
  // ---------------------------------------------------------------
  always #12.5 core_clk = ~core_clk;

  // the whole run needs a few hundred cycles; far beyond means a hang
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic close_out();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data lands on the edge after the strobe and only there
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask

  // issue a dump, then judge order, values and status bits
  task automatic do_dump(input logic [2:0] op);
    logic [31:0] st;
    int          k;
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    wr(REG_CMD, {29'h0, op});
    k = 0;
    while (sink.n_acc < NUM_CNT && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    repeat (3) @(posedge core_clk);
    check(32'(sink.n_acc), 32'(NUM_CNT));
    for (int i = 0; i < NUM_CNT; i++) begin
      check({24'h0, sink.ord[i]}, 32'(4 * i));
      check(sink.mem[i], expect_cnt[i]);
    end
    rd(REG_STATUS, st);
    check({29'h0, st[2:0]}, {29'h0, op == CMD_DUMP_RESET, 2'b10});
    rd(REG_STATUS, st);
    check({31'h0, st[1]}, 32'h0);
    if (op == CMD_DUMP_RESET)
      foreach (expect_cnt[i]) expect_cnt[i] = '0;
  endtask

  // one transmit frame; idle status is junk that must not count
  task automatic tx_ev(input tx_status_t s);
    @(posedge core_clk);
    tx_done <= 1'b1;
    tx_status <= s;
    @(posedge core_clk);
    tx_done <= 1'b0;
    tx_status <= '1;
    expect_cnt[I_TX_GOOD]    += 32'(s.good);
    expect_cnt[I_TX_MAXCOLL] += 32'(s.max_coll);
    expect_cnt[I_TX_LATE]    += 32'(s.late_coll);
    expect_cnt[I_TX_LOSTCRS] += 32'(s.lost_crs & s.good);
    expect_cnt[I_TX_DEFER]   += 32'(s.deferred);
    expect_cnt[I_TX_SINGLE]  += 32'(s.good && s.coll == 5'd1);
    expect_cnt[I_TX_MULTI]   += 32'(s.good && s.coll > 5'd1);
    expect_cnt[I_TX_TOTAL]   += 32'(s.coll);
  endtask

  // one receive frame with the error pin held through its body
  task automatic rx_ev(input rx_status_t s, input logic er,
                       input logic nores);
    logic sh;
    logic al;
    logic cr;
    @(posedge core_clk);
    rx_active <= 1'b1;
    rx_er <= er;
    repeat (3) @(posedge core_clk);
    rx_er <= 1'b0;
    rx_active <= 1'b0;
    rx_done <= 1'b1;
    rx_status <= s;
    ru_no_resources <= nores;
    @(posedge core_clk);
    rx_done <= 1'b0;
    rx_status <= '1;
    ru_no_resources <= 1'b0;
    sh = s.short_frame;
    al = !sh && s.misaligned && s.crc_err;
    cr = !sh && !al && (s.crc_err || er);
    expect_cnt[I_RX_GOOD]  += 32'(s.good_stored);
    expect_cnt[I_RX_ALIGN] += 32'(al);
    expect_cnt[I_RX_CRC]   += 32'(cr);
    expect_cnt[I_RX_RES]   +=
      32'(nores || (s.no_buffer && !(save_bad && s.bad)));
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_state();
    logic [31:0] d;
    rd(REG_CFG, d);
    check(d, 32'h0);
    rd(8'h0c, d);
    check(d, 32'h0);
    do_dump(CMD_DUMP);
    $display("test reset_state done");
  endtask

  task automatic t_tx();
    tx_ev(10'b10000_00001);
    tx_ev(10'b10000_00011);
    tx_ev(10'b10011_00000);
    tx_ev(10'b01000_10000);
    tx_ev(10'b00100_00001);
    @(posedge core_clk);
    tx_underrun <= 1'b1;
    repeat (3) @(posedge core_clk);
    tx_underrun <= 1'b0;
    expect_cnt[I_TX_UNDER] += 32'd3;
    slow <= 1'b1;
    do_dump(CMD_DUMP_RESET);
    slow <= 1'b0;
    do_dump(CMD_DUMP);
    $display("test tx done");
  endtask

  task automatic t_rx();
    logic [31:0] d;
    rx_ev(6'b100000, 1'b0, 1'b0);
    rx_ev(6'b010000, 1'b0, 1'b1);
    rx_ev(6'b000000, 1'b1, 1'b0);
    rx_ev(6'b010000, 1'b1, 1'b0);
    rx_ev(6'b011000, 1'b0, 1'b0);
    rx_ev(6'b010100, 1'b1, 1'b0);
    rx_ev(6'b000010, 1'b0, 1'b0);
    wr(REG_CFG, 32'h1);
    save_bad = 1'b1;
    rd(REG_CFG, d);
    check(d, 32'h1);
    rx_ev(6'b000011, 1'b0, 1'b0);
    rx_ev(6'b000011, 1'b0, 1'b1);
    do_dump(CMD_DUMP);
    $display("test rx done");
  endtask

  // events during a dump-and-reset land in the snapshot or in the
  // fresh count, never both; a command while busy is ignored
  task automatic t_clear_race();
    logic [31:0] tot;
    int          k;
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    wr(REG_CMD, {29'h0, CMD_DUMP_RESET});
    wr(REG_CMD, {29'h0, CMD_DUMP});
    @(posedge core_clk);
    repeat (12) tx_ev(10'b00000_00001);
    k = 0;
    while (sink.n_acc < NUM_CNT && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    repeat (3) @(posedge core_clk);
    check(32'(sink.n_acc), 32'(NUM_CNT));
    for (int i = 0; i < NUM_CNT; i++) begin
      if (i != I_TX_TOTAL)
        check(sink.mem[i], expect_cnt[i]);
    end
    check(32'(sink.mem[I_TX_TOTAL] inside {[1:11]}), 32'h1);
    tot = expect_cnt[I_TX_TOTAL] - sink.mem[I_TX_TOTAL];
    foreach (expect_cnt[i]) expect_cnt[i] = '0;
    expect_cnt[I_TX_TOTAL] = tot;
    do_dump(CMD_DUMP);
    $display("test clear_race done");
  endtask

  // a reset in mid-run clears every counter and the configuration
  task automatic t_mid_reset();
    logic [31:0] d;
    tx_ev(10'b10011_00010);
    wr(REG_CFG, 32'h1);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    save_bad = 1'b0;
    foreach (expect_cnt[i]) expect_cnt[i] = '0;
    rd(REG_CFG, d);
    check(d, 32'h0);
    wr(REG_CMD, {29'h0, 3'h5});
    rd(REG_STATUS, d);
    check(d, 32'h0);
    do_dump(CMD_DUMP);
    $display("test mid_reset done");
  endtask

  initial begin
    foreach (expect_cnt[i]) expect_cnt[i] = '0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset_state();
    t_tx();
    t_rx();
    t_clear_race();
    t_mid_reset();
    close_out();
  end
endmodule
